// >>> include/pgf_pkg.sv
// package of register map, field layout and reset values for pwm fault/irq
package pgf_pkg;
    localparam int unsigned ADDR_W = 12;
    // register byte offsets
    localparam logic [11:0] OFS_CONFIG = 12'h000;
    localparam logic [11:0] OFS_FLT_SEL0 = 12'h004;
    localparam logic [11:0] OFS_FLT_SEL1 = 12'h008;
    localparam logic [11:0] OFS_FLT_SENSE = 12'h00C;
    localparam logic [11:0] OFS_FLT_STAT0 = 12'h010;
    localparam logic [11:0] OFS_FLT_STAT1 = 12'h014;
    localparam logic [11:0] OFS_INT_EN = 12'h018;
    localparam logic [11:0] OFS_RAW_IS = 12'h01C;
    localparam logic [11:0] OFS_MASK_IS = 12'h020;
    localparam logic [11:0] OFS_PERIOD = 12'h024;
    localparam logic [11:0] OFS_ACT_PERIOD = 12'h028;
    localparam logic [11:0] OFS_MOD_EN = 12'h02C;
    // config register fields
    localparam int unsigned CFG_EXT_SRC = 0;
    localparam int unsigned CFG_LATCHED = 1;
    localparam int unsigned CFG_W = 2;
    // interrupt enable fields (irq bits 5:0, trigger bits 11:8)
    localparam int unsigned IRQ_W = 6;
    localparam int unsigned INTEN_W = 12;
    localparam int unsigned TRG_LSB = 8;
    localparam int unsigned IRQ_ZERO = 0;
    localparam int unsigned IRQ_LOAD = 1;
    localparam int unsigned IRQ_AU = 2;
    localparam int unsigned IRQ_AD = 3;
    localparam int unsigned IRQ_BU = 4;
    localparam int unsigned IRQ_BD = 5;
    // group widths
    localparam int unsigned EXT_N = 4;
    localparam int unsigned DCMP_N = 8;
    localparam int unsigned PER_W = 16;
    // reset values
    localparam logic [3:0] SEL0_RST = 4'h1;
    localparam logic [7:0] SEL1_RST = 8'h00;
    localparam logic [15:0] PER_RST = 16'h0000;
endpackage

// >>> hdl/pgf_fault_irq.sv
// per-generator fault source combine, interrupt status and period logic
//
// Operation
// - fault is OR of selected triggers, only external inputs sense-adjusted
// - four external, eight comparator select bits
// - reset uses fault zero until extended mode
// - selected trigger sets read back per group
// - write one clears status, zero keeps
// - enable register holds irq and trigger enables
// - raw and masked status both readable
// - irq needs module enable and pending source
// - period counts ticks between zero pulses
// - period read gives programmed, not active value
// - latched mode holds trigger status until cleared
`timescale 1ns/100ps
module pgf_fault_irq
    import pgf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] externalFaultInput,
    input wire logic [7:0] digitalComparatorTrigger,
    input wire logic counterLoadEvent,
    input wire logic cmpAUpEvent,
    input wire logic cmpADownEvent,
    input wire logic cmpBUpEvent,
    input wire logic cmpBDownEvent,
    output logic faultOut,
    output logic counterZero,
    output logic genIrq,
    output logic [3:0] genTrigger
);
    typedef enum logic [1:0] {
        PGF_IDLE = 2'b01,
        PGF_ACCESS = 2'b10
    } pgf_bus_t;

    pgf_bus_t busState_reg;
    logic [CFG_W-1:0] config_reg;
    logic [3:0] sel0_reg;
    logic [7:0] sel1_reg;
    logic [3:0] sense_reg;
    logic [3:0] stat0_reg;
    logic [7:0] stat1_reg;
    logic [INTEN_W-1:0] intEn_reg;
    logic [IRQ_W-1:0] rawIs_reg;
    logic modEn_reg;
    logic [PER_W-1:0] period_reg;
    logic [PER_W-1:0] actPeriod_reg;
    logic [PER_W-1:0] count_reg;
    logic updPending_reg;
    logic [31:0] prdata_reg;
    logic faultOut_reg;
    logic zeroPulse_reg;
    logic genIrq_reg;
    logic [3:0] genTrigger_reg;

    logic wrEn;
    logic rdEn;
    logic [3:0] extAdj;
    logic [3:0] effSel0;
    logic [7:0] effSel1;
    logic [IRQ_W-1:0] events;
    logic [IRQ_W-1:0] maskIs;
    logic addrOk;

    // true when the address matches a given register offset
    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a == o);
    endfunction

    // address decode for mapped registers
    always_comb
    begin
        case (paddr)
            OFS_CONFIG, OFS_FLT_SEL0, OFS_FLT_SEL1, OFS_FLT_SENSE,
            OFS_FLT_STAT0, OFS_FLT_STAT1, OFS_INT_EN, OFS_RAW_IS,
            OFS_MASK_IS, OFS_PERIOD, OFS_ACT_PERIOD, OFS_MOD_EN:
                addrOk = 1'b1;
            default:
                addrOk = 1'b0;
        endcase
    end

    // apb handshake: no wait state, answer in the access phase
    assign pready = (busState_reg == PGF_ACCESS);
    assign pslverr = pready & ~addrOk;
    assign wrEn = clkEn & psel & penable & pready & pwrite & addrOk;
    assign rdEn = clkEn & psel & ~penable & ~pwrite;
    assign prdata = prdata_reg;

    // bus state: setup moves to access, access returns to idle
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            busState_reg <= PGF_IDLE;
        else if (clkEn)
        begin
            case (busState_reg)
                PGF_IDLE:
                    if (psel && !penable)
                        busState_reg <= PGF_ACCESS;
                PGF_ACCESS:
                    busState_reg <= PGF_IDLE;
                default:
                    busState_reg <= PGF_IDLE;
            endcase
        end
    end

    // sense adjust then pick the effective selection
    always_comb
    begin
        extAdj = externalFaultInput ^ sense_reg;
        if (config_reg[CFG_EXT_SRC])
        begin
            effSel0 = sel0_reg;
            effSel1 = sel1_reg;
        end
        else
        begin
            effSel0 = SEL0_RST;
            effSel1 = SEL1_RST;
        end
    end

    // combined fault is a registered OR of the selected sources
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            faultOut_reg <= 1'b0;
        else if (clkEn)
            faultOut_reg <= |(extAdj & effSel0) |
                |(digitalComparatorTrigger & effSel1);
    end
    assign faultOut = faultOut_reg;

    // trigger status: live or latched with write-one clear, set wins
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            stat0_reg <= 4'h0;
            stat1_reg <= 8'h00;
        end
        else if (clkEn)
        begin
            if (config_reg[CFG_LATCHED])
            begin
                stat0_reg <= (stat0_reg & ~(hit(paddr, OFS_FLT_STAT0) &&
                    wrEn ? pwdata[3:0] : 4'h0)) | extAdj;
                stat1_reg <= (stat1_reg & ~(hit(paddr, OFS_FLT_STAT1) &&
                    wrEn ? pwdata[7:0] : 8'h00)) |
                    digitalComparatorTrigger;
            end
            else
            begin
                stat0_reg <= extAdj;
                stat1_reg <= digitalComparatorTrigger;
            end
        end
    end

    // configuration registers written by software
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            config_reg <= '0;
            sel0_reg <= SEL0_RST;
            sel1_reg <= SEL1_RST;
            sense_reg <= 4'h0;
            intEn_reg <= '0;
            modEn_reg <= 1'b0;
        end
        else if (wrEn)
        begin
            if (hit(paddr, OFS_CONFIG))
                config_reg <= pwdata[CFG_W-1:0];
            if (hit(paddr, OFS_FLT_SEL0))
                sel0_reg <= pwdata[EXT_N-1:0];
            if (hit(paddr, OFS_FLT_SEL1))
                sel1_reg <= pwdata[DCMP_N-1:0];
            if (hit(paddr, OFS_FLT_SENSE))
                sense_reg <= pwdata[EXT_N-1:0];
            if (hit(paddr, OFS_INT_EN))
                intEn_reg <= pwdata[INTEN_W-1:0];
            if (hit(paddr, OFS_MOD_EN))
                modEn_reg <= pwdata[0];
        end
    end

    // period: programmed value, taken by the counter at zero
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            period_reg <= PER_RST;
            actPeriod_reg <= PER_RST;
            updPending_reg <= 1'b0;
            count_reg <= '0;
            zeroPulse_reg <= 1'b0;
        end
        else if (clkEn)
        begin
            zeroPulse_reg <= (count_reg == '0);
            if (wrEn && hit(paddr, OFS_PERIOD))
            begin
                period_reg <= pwdata[PER_W-1:0];
                updPending_reg <= 1'b1;
            end
            if (count_reg == '0)
            begin
                // a period of n gives n ticks between zero pulses; a period of zero gives one tick, as one does
                if (updPending_reg && !(wrEn && hit(paddr, OFS_PERIOD)))
                begin
                    actPeriod_reg <= period_reg;
                    updPending_reg <= 1'b0;
                    count_reg <= (period_reg == '0) ? '0 :
                        period_reg - 16'h0001;
                end
                else
                    count_reg <= (actPeriod_reg == '0) ? '0 :
                        actPeriod_reg - 16'h0001;
            end
            else
                count_reg <= count_reg - 16'h0001;
        end
    end
    assign counterZero = zeroPulse_reg;

    // raw interrupt status: events set, write one clears, set wins
    assign events = {cmpBDownEvent, cmpBUpEvent, cmpADownEvent,
        cmpAUpEvent, counterLoadEvent, zeroPulse_reg};
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            rawIs_reg <= '0;
        else if (clkEn)
        begin
            if (wrEn && (hit(paddr, OFS_RAW_IS) || hit(paddr, OFS_MASK_IS)))
                rawIs_reg <= (rawIs_reg & ~pwdata[IRQ_W-1:0]) | events;
            else
                rawIs_reg <= rawIs_reg | events;
        end
    end

    // masked status follows raw and enables combinationally
    assign maskIs = rawIs_reg & intEn_reg[IRQ_W-1:0];

    // generator interrupt and trigger outputs
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            genIrq_reg <= 1'b0;
            genTrigger_reg <= 4'h0;
        end
        else if (clkEn)
        begin
            genIrq_reg <= modEn_reg & (|maskIs);
            genTrigger_reg <= intEn_reg[TRG_LSB+3:TRG_LSB] &
                {cmpBDownEvent, cmpBUpEvent, counterLoadEvent,
                zeroPulse_reg};
        end
    end
    assign genIrq = genIrq_reg;
    assign genTrigger = genTrigger_reg;

    // read data captured in the setup cycle
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            prdata_reg <= 32'h00000000;
        else if (rdEn)
        begin
            case (paddr)
                OFS_CONFIG: prdata_reg <= {30'h0, config_reg};
                OFS_FLT_SEL0: prdata_reg <= {28'h0, sel0_reg};
                OFS_FLT_SEL1: prdata_reg <= {24'h0, sel1_reg};
                OFS_FLT_SENSE: prdata_reg <= {28'h0, sense_reg};
                OFS_FLT_STAT0: prdata_reg <= {28'h0, stat0_reg};
                OFS_FLT_STAT1: prdata_reg <= {24'h0, stat1_reg};
                OFS_INT_EN: prdata_reg <= {20'h0, intEn_reg};
                OFS_RAW_IS: prdata_reg <= {26'h0, rawIs_reg};
                OFS_MASK_IS: prdata_reg <= {26'h0, maskIs};
                OFS_PERIOD: prdata_reg <= {16'h0, period_reg};
                OFS_ACT_PERIOD: prdata_reg <= {16'h0, actPeriod_reg};
                OFS_MOD_EN: prdata_reg <= {31'h0, modEn_reg};
                default: prdata_reg <= 32'h00000000;
            endcase
        end
    end
endmodule

// >>> bench/pgf_fault_irq_chk.sv
// port checker for the fault and interrupt block, bound to it
`timescale 1ns/100ps
module pgf_fault_irq_chk (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic counterLoadEvent,
    input wire logic cmpBUpEvent,
    input wire logic cmpBDownEvent,
    input wire logic faultOut,
    input wire logic genIrq,
    input wire logic [3:0] genTrigger
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // bus answer timing and error response
    ready_after_a: assert property (psel && !penable && clkEn |=> pready)
        else $error("no ready after setup");
    ready_only_a: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    ready_once_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    err_data_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("error read not zero");
    // load and compare B triggers only follow their own event
    trig_load_a: assert property (genTrigger[1] && $past(clkEn) |->
        $past(counterLoadEvent))
        else $error("load trigger without event");
    trig_bu_a: assert property (genTrigger[2] && $past(clkEn) |->
        $past(cmpBUpEvent))
        else $error("b up trigger without event");
    trig_bd_a: assert property (genTrigger[3] && $past(clkEn) |->
        $past(cmpBDownEvent))
        else $error("b down trigger without event");
    // main scenarios seen
    cover property (pslverr);
    cover property ($rose(genIrq));
    cover property ($rose(faultOut));
endmodule

bind pgf_fault_irq pgf_fault_irq_chk chk_u (.clk_sys, .nrst, .clkEn, .psel,
    .penable, .pwrite, .prdata, .pready, .pslverr, .counterLoadEvent,
    .cmpBUpEvent,
    .cmpBDownEvent, .faultOut, .genIrq, .genTrigger);

// >>> bench/pgf_fault_src.sv
// far-side model: fault pins, comparator triggers and counter events
`timescale 1ns/100ps
module pgf_fault_src (
    input wire logic clk_sys,
    input wire logic [3:0] extReq,
    input wire logic [7:0] dcmpReq,
    input wire logic [4:0] evtReq,
    output logic [3:0] extFault,
    output logic [7:0] dcmpTrig,
    output logic [4:0] evtPulse
);
    // levels and one-cycle pulses launched on the rising edge
    always_ff @(posedge clk_sys)
    begin
        extFault <= extReq;
        dcmpTrig <= dcmpReq;
        evtPulse <= evtReq;
    end
endmodule

// >>> bench/pgf_fault_irq_tb.sv
// self-checking bench for the fault and interrupt block
`timescale 1ns/100ps
module pgf_fault_irq_tb;
    import pgf_pkg::*;
    logic clk_sys, nrst, clkEn, psel, penable, pwrite, pready, pslverr;
    logic faultOut, counterZero, genIrq, e;
    logic [11:0] paddr, ien;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] extReq, extFault, genTrigger, s0, sn, x;
    logic [7:0] dcmpReq, dcmpTrig, s1, d;
    logic [4:0] evtReq, evtPulse;
    int n_mismatch, compares, cyc, per;
    pgf_fault_src src_u (.clk_sys, .extReq, .dcmpReq, .evtReq, .extFault,
        .dcmpTrig, .evtPulse);
    pgf_fault_irq dut_u (.clk_sys, .nrst, .clkEn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr,
        .externalFaultInput(extFault), .digitalComparatorTrigger(dcmpTrig),
        .counterLoadEvent(evtPulse[0]), .cmpAUpEvent(evtPulse[1]),
        .cmpADownEvent(evtPulse[2]), .cmpBUpEvent(evtPulse[3]),
        .cmpBDownEvent(evtPulse[4]), .faultOut, .counterZero, .genIrq,
        .genTrigger);
    // clock at 4 ns
    initial
    begin
        clk_sys = 0;
        forever #2 clk_sys = ~clk_sys;
    end
    // expected combined fault
    function automatic logic fexp(logic [3:0] p, sv, m, logic [7:0] q, k);
        return |((p ^ sv) & m) | |(q & k);
    endfunction
    task automatic end_of_test();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer, answer taken at the edge that samples pready high
    task automatic bus(input logic w, input logic [11:0] a,
        input logic [31:0] wd);
        int n;
        logic ok;
        ok = 0;
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
        @(posedge clk_sys);
        penable <= 1;
        for (n = 0; n < 20 && !ok; n++)
        begin
            @(posedge clk_sys);
            ok = pready === 1'b1;
        end
        if (!ok)
        begin
            n_mismatch++;
            end_of_test();
        end
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic settle();
        repeat (4) @(negedge clk_sys);
    endtask
    task automatic drv(input logic [3:0] p, input logic [7:0] q);
        @(posedge clk_sys);
        {extReq, dcmpReq} <= {p, q};
        settle();
    endtask
    task automatic wait_zero();
        cyc = 0;
        do
        begin
            @(negedge clk_sys);
            cyc++;
        end while (counterZero !== 1'b1 && cyc < 1000);
        if (cyc >= 1000)
        begin
            n_mismatch++;
            end_of_test();
        end
    endtask
    initial
    begin
        {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
        clkEn = 1'b1;
        {extReq, dcmpReq, evtReq, n_mismatch, compares} = 0;
        void'($urandom(32'h0144));
        repeat (6) @(posedge clk_sys);
        nrst <= 1;
        bus(0, OFS_FLT_SEL0, 0); chk(r, 32'h1);
        bus(0, OFS_FLT_SEL1, 0); chk(r, 32'h0);
        bus(0, 12'h100, 0); chk({e, r[30:0]}, 32'h80000000);
        drv(4'hE, 8'hFF); chk(faultOut, 1'b0);
        drv(4'h1, 8'h00); chk(faultOut, 1'b1);
        bus(1, OFS_CONFIG, 32'h1);
        for (int i = 0; i < 10; i++)
        begin
            {s0, sn, x, s1, d} = (i == 0) ? 28'h0 : 28'($urandom);
            bus(1, OFS_FLT_SEL0, s0);
            bus(1, OFS_FLT_SEL1, s1);
            bus(1, OFS_FLT_SENSE, sn);
            drv(x, d); chk(faultOut, fexp(x, sn, s0, d, s1));
            bus(0, OFS_FLT_SEL1, 0); chk(r, s1);
        end
        // quiet the triggers first so latched mode starts from empty comparator status
        drv(4'h0, 8'h00); chk(faultOut, fexp(4'h0, sn, s0, 8'h00, s1));
        bus(1, OFS_FLT_SEL1, 32'hFF);
        bus(1, OFS_CONFIG, 32'h3);
        drv(4'h0, 8'h24);
        drv(4'h0, 8'h00);
        bus(0, OFS_FLT_STAT1, 0); chk(r, 32'h24);
        bus(1, OFS_FLT_STAT1, 32'h04);
        bus(0, OFS_FLT_STAT1, 0); chk(r, 32'h20);
        bus(1, OFS_CONFIG, 32'h1);
        bus(0, OFS_FLT_STAT1, 0); chk(r, 32'h0);
        ien = (12'($urandom) & 12'h13E) | 12'hE02;
        bus(1, OFS_INT_EN, ien);
        bus(0, OFS_INT_EN, 0); chk(r, ien);
        @(posedge clk_sys);
        evtReq <= 5'h1F;
        @(posedge clk_sys);
        evtReq <= 5'h00;
        // trigger pulse stands one cycle, two edges after the request
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk(genTrigger, ien[11:8]);
        settle(); chk(genIrq, 1'b0);
        bus(1, OFS_RAW_IS, 32'h1);
        bus(0, OFS_RAW_IS, 0); chk(r & 32'h3E, 32'h3E);
        bus(0, OFS_MASK_IS, 0); chk(r & 32'h3E, ien & 12'h3E);
        bus(1, OFS_MOD_EN, 32'h1);
        settle(); chk(genIrq, 1'b1);
        bus(1, OFS_RAW_IS, 32'h3E);
        bus(0, OFS_RAW_IS, 0); chk(r & 32'h3E, 32'h0);
        settle(); chk(genIrq, 1'b0);
        per = 3 + $urandom % 40;
        bus(1, OFS_PERIOD, per);
        bus(0, OFS_PERIOD, 0); chk(r, per);
        repeat (3) wait_zero();
        chk(cyc, per);
        end_of_test();
    end
endmodule
